// [hw/mwj_regs.sv]
// Watchdog/jabber control and added interrupt registers behind AXI4-Lite
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "mwj_cfg.svh"
module mwj_regs #(
  parameter int unsigned JAB_FAST_CYC = `MWJ_US_CYC(`MWJ_JAB_FAST_US),
  parameter int unsigned JAB_SLOW_CYC = `MWJ_US_CYC(`MWJ_JAB_SLOW_US),
  parameter int unsigned HOLD_FAST_CYC = `MWJ_US_CYC(`MWJ_HOLD_FAST_US),
  parameter int unsigned HOLD_SLOW_CYC = `MWJ_US_CYC(`MWJ_HOLD_SLOW_US),
  parameter logic [31:0] MAIN_STAT_RST = 32'h00000000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // AXI4-Lite write address, data and response
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Strap from configuration memory, captured when loaded
  input wire logic rx_clock_invert_load_i,
  input wire logic rx_clock_invert_val_i,
  // MAC events and line state
  input wire mwj_pkg::mwj_events_s events_i,
  input wire logic pause_enabled_i,
  input wire logic [14:0] main_status_set_i,
  input wire logic speed_100_i,
  input wire logic tx_active_i,
  input wire logic rx_active_i,
  input wire logic rx_carrier_i,
  input wire logic mii_rx_clk_i,
  // Outputs
  output logic mii_rx_clk_o,
  output logic tx_blocked_o,
  output logic rx_watchdog_expired_o,
  output logic rx_watchdog_release_o,
  output logic irq_o,
  output logic main_normal_summary_o,
  output logic main_abnormal_summary_o
);
  logic [5:0] ctrl;
  logic rx_clock_invert;
  logic [31:0] stat;
  logic [31:0] ien;
  logic [31:0] next_stat;
  logic [31:0] next_ien;
  logic [5:0] next_ctrl;
  logic next_rx_clock_invert;
  logic aw_hold, w_hold, next_aw_hold, next_w_hold;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic aw_rdy, w_rdy, ar_rdy;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp, bresp, next_bresp;
  logic do_wr;
  logic [31:0] wmask;
  logic [31:0] ev_vec;
  mwj_pkg::mwj_jab_e jst, next_jst;
  logic jab_clr, jab_done, hold_clr, hold_done, wd_done, rel_done;
  logic [23:0] jab_lim, hold_lim, wd_lim, rel_lim;
  logic next_tx_blocked, next_wd_exp, next_wd_rel, next_irq, next_ns, next_as, next_rxc;

  // Write happens once address and data both held
  assign do_wr = aw_hold && w_hold && !bvalid;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{w_strb[i]}};
    end
  end

  // Bus channel next state
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid_i && !aw_hold) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !w_hold) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (do_wr) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr == `MWJ_OFF_CTRL || aw_addr == `MWJ_OFF_STAT ||
                    aw_addr == `MWJ_OFF_IEN) ? 2'h0 : 2'h2;
    end else if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid_i && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = 2'h0;
      unique case (s_axi_araddr_i)
        `MWJ_OFF_CTRL: next_rdata = {3'h0, rx_clock_invert, 22'h0, ctrl};
        `MWJ_OFF_STAT: next_rdata = stat;
        `MWJ_OFF_IEN: next_rdata = ien;
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = 2'h2;
        end
      endcase
    end else if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
  end

  // Event vector at status positions
  always_comb begin
    ev_vec = 32'h00000000;
    ev_vec[`MWJ_B_ETX] = events_i.tx_in_fifo && ien[`MWJ_B_ETX];
    ev_vec[`MWJ_B_ERX] = events_i.rx_first_desc && ien[`MWJ_B_ERX];
    ev_vec[`MWJ_B_LNK] = events_i.link_change;
    ev_vec[`MWJ_B_DEF] = events_i.tx_deferred;
    ev_vec[`MWJ_B_PAU] = events_i.pause_rx && pause_enabled_i;
    ev_vec[14:0] = main_status_set_i;
    ev_vec[`MWJ_B_NSUM] = ev_vec[`MWJ_B_ETX] | ev_vec[`MWJ_B_ERX];
    ev_vec[`MWJ_B_ASUM] = ev_vec[`MWJ_B_LNK] | ev_vec[`MWJ_B_DEF] |
                          ev_vec[`MWJ_B_PAU];
  end

  // Register file next values
  always_comb begin
    next_ctrl = ctrl;
    next_ien = ien;
    next_stat = stat;
    next_rx_clock_invert = rx_clock_invert;
    if (rx_clock_invert_load_i) begin
      next_rx_clock_invert = rx_clock_invert_val_i;
    end
    if (do_wr && aw_addr == `MWJ_OFF_CTRL) begin
      next_ctrl = (ctrl & ~wmask[5:0]) | (w_data[5:0] & wmask[5:0] &
                  6'(`MWJ_CTRL_WMASK));
    end
    if (do_wr && aw_addr == `MWJ_OFF_IEN) begin
      next_ien = (w_data & wmask & (`MWJ_ADD_MASK | 32'h00007fff)) |
                 (ien & ~wmask);
    end
    if (do_wr && aw_addr == `MWJ_OFF_STAT) begin
      next_stat = stat & ~(w_data & wmask);
    end
    next_stat = next_stat | ev_vec;
  end

  // Register file and bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= 6'h00;
      ien <= 32'h00000000;
      stat <= MAIN_STAT_RST;
      rx_clock_invert <= 1'b0;
      aw_hold <= 1'b0;
      aw_rdy <= 1'b1;
      w_rdy <= 1'b1;
      ar_rdy <= 1'b1;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
    end else begin
      ctrl <= next_ctrl;
      ien <= next_ien;
      stat <= next_stat;
      rx_clock_invert <= next_rx_clock_invert;
      aw_hold <= next_aw_hold;
      aw_rdy <= !next_aw_hold;
      w_rdy <= !next_w_hold;
      ar_rdy <= !next_rvalid;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // Jabber and release limits by select and speed; hold-off and watchdog limits by speed alone
  always_comb begin
    if (ctrl[`MWJ_B_JAB_SEL]) begin
      jab_lim = 24'(`MWJ_BT_CYC(`MWJ_JAB_BYTES * 8,
                speed_100_i ? `MWJ_NS_100 : `MWJ_NS_10));
    end else begin
      jab_lim = speed_100_i ? 24'(JAB_FAST_CYC) : 24'(JAB_SLOW_CYC);
    end
    hold_lim = speed_100_i ? 24'(HOLD_FAST_CYC) : 24'(HOLD_SLOW_CYC);
    wd_lim = 24'(`MWJ_BT_CYC(`MWJ_WD_BYTES * 8, speed_100_i ? `MWJ_NS_100 : `MWJ_NS_10));
    rel_lim = ctrl[`MWJ_B_REL_SEL] ?
      24'(`MWJ_BT_CYC(`MWJ_REL_LONG_BT, speed_100_i ? `MWJ_NS_100 : `MWJ_NS_10)) :
      24'(`MWJ_BT_CYC(`MWJ_REL_SHORT_BT, speed_100_i ? `MWJ_NS_100 : `MWJ_NS_10));
  end

  // Jabber state machine
  always_comb begin
    next_jst = jst;
    jab_clr = 1'b1;
    hold_clr = 1'b1;
    unique case (jst)
      mwj_pkg::MWJ_J_IDLE: begin
        if (tx_active_i && !ctrl[`MWJ_B_JAB_DIS]) begin
          next_jst = mwj_pkg::MWJ_J_RUN;
        end
      end
      mwj_pkg::MWJ_J_RUN: begin
        jab_clr = 1'b0;
        if (ctrl[`MWJ_B_JAB_DIS] || !tx_active_i) begin
          next_jst = mwj_pkg::MWJ_J_IDLE;
        end else if (jab_done) begin
          next_jst = ctrl[`MWJ_B_JAB_IMM] ? mwj_pkg::MWJ_J_WAIT : mwj_pkg::MWJ_J_HOLD;
        end
      end
      mwj_pkg::MWJ_J_HOLD: begin
        hold_clr = 1'b0;
        if (ctrl[`MWJ_B_JAB_DIS]) begin
          next_jst = mwj_pkg::MWJ_J_IDLE;
        end else if (hold_done) begin
          next_jst = mwj_pkg::MWJ_J_WAIT;
        end
      end
      mwj_pkg::MWJ_J_WAIT: begin
        if (!tx_active_i) begin
          next_jst = mwj_pkg::MWJ_J_IDLE;
        end
      end
    endcase
  end

  mwj_cnt #(.W(24)) u_jab (.clk_i(clk_i), .rst_i(rst_i), .clr_i(jab_clr),
    .run_i(tx_active_i), .limit_i(jab_lim), .done_o(jab_done));
  mwj_cnt #(.W(24)) u_hold (.clk_i(clk_i), .rst_i(rst_i), .clr_i(hold_clr),
    .run_i(1'b1), .limit_i(hold_lim), .done_o(hold_done));
  mwj_cnt #(.W(24)) u_wd (.clk_i(clk_i), .rst_i(rst_i),
    .clr_i(!rx_active_i || ctrl[`MWJ_B_WD_DIS]), .run_i(1'b1), .limit_i(wd_lim),
    .done_o(wd_done));
  mwj_cnt #(.W(24)) u_rel (.clk_i(clk_i), .rst_i(rst_i), .clr_i(rx_carrier_i),
    .run_i(1'b1), .limit_i(rel_lim), .done_o(rel_done));

  // Output next values
  always_comb begin
    next_tx_blocked = (next_jst == mwj_pkg::MWJ_J_HOLD);
    next_wd_exp = wd_done && !ctrl[`MWJ_B_WD_DIS];
    next_wd_rel = rel_done;
    next_irq = |(next_stat & next_ien);
    next_ns = ien[`MWJ_B_NSUM] && (next_stat[`MWJ_B_ETX] | next_stat[`MWJ_B_ERX]);
    next_as = ien[`MWJ_B_ASUM] && (next_stat[`MWJ_B_PAU] | next_stat[`MWJ_B_DEF] |
              next_stat[`MWJ_B_LNK]);
    next_rxc = mii_rx_clk_i ^ next_rx_clock_invert;
  end

  // Output and state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jst <= mwj_pkg::MWJ_J_IDLE;
      tx_blocked_o <= 1'b0;
      rx_watchdog_expired_o <= 1'b0;
      rx_watchdog_release_o <= 1'b0;
      irq_o <= 1'b0;
      main_normal_summary_o <= 1'b0;
      main_abnormal_summary_o <= 1'b0;
      mii_rx_clk_o <= 1'b0;
    end else begin
      jst <= next_jst;
      tx_blocked_o <= next_tx_blocked;
      rx_watchdog_expired_o <= next_wd_exp;
      rx_watchdog_release_o <= next_wd_rel;
      irq_o <= next_irq;
      main_normal_summary_o <= next_ns;
      main_abnormal_summary_o <= next_as;
      mii_rx_clk_o <= next_rxc;
    end
  end

  // Bus outputs
  assign s_axi_awready_o = aw_rdy;
  assign s_axi_wready_o = w_rdy;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_arready_o = ar_rdy;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;

  // Checks
  property p_latch;
    @(posedge clk_i) disable iff (rst_i)
      stat[`MWJ_B_LNK] && !(do_wr && aw_addr == `MWJ_OFF_STAT) |=> stat[`MWJ_B_LNK];
  endproperty
  a_latch: assert property (p_latch) else $error("status bit lost");
  property p_early_gate;
    @(posedge clk_i) disable iff (rst_i)
      !$past(stat[`MWJ_B_ETX]) && stat[`MWJ_B_ETX] |-> $past(ien[`MWJ_B_ETX]);
  endproperty
  a_early_gate: assert property (p_early_gate) else $error("early tx set while disabled");
  property p_irq;
    @(posedge clk_i) disable iff (rst_i) irq_o == |(stat & ien);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_jbd;
    @(posedge clk_i) disable iff (rst_i) ctrl[`MWJ_B_JAB_DIS] |=> jst != mwj_pkg::MWJ_J_HOLD;
  endproperty
  a_jbd: assert property (p_jbd) else $error("jabber active while disabled");
  property p_nj;
    @(posedge clk_i) disable iff (rst_i)
      jst == mwj_pkg::MWJ_J_RUN && ctrl[`MWJ_B_JAB_IMM] |=> jst != mwj_pkg::MWJ_J_HOLD;
  endproperty
  a_nj: assert property (p_nj) else $error("hold-off with immediate re-enable");
  property p_rwd;
    @(posedge clk_i) disable iff (rst_i) ctrl[`MWJ_B_WD_DIS] |=> !rx_watchdog_expired_o;
  endproperty
  a_rwd: assert property (p_rwd) else $error("watchdog expired while disabled");
  property p_sum;
    @(posedge clk_i) disable iff (rst_i) stat[`MWJ_B_LNK] && !$past(stat[`MWJ_B_LNK])
      |-> stat[`MWJ_B_ASUM];
  endproperty
  a_sum: assert property (p_sum) else $error("abnormal summary missing");
  property p_rxc;
    @(posedge clk_i) disable iff (rst_i) 1'b1 |=> mii_rx_clk_o ==
      ($past(mii_rx_clk_i) ^ rx_clock_invert);
  endproperty
  a_rxc: assert property (p_rxc) else $error("rx clock polarity wrong");
  c_hold: cover property (@(posedge clk_i) jst == mwj_pkg::MWJ_J_HOLD);
  c_irq: cover property (@(posedge clk_i) irq_o);
  c_wd: cover property (@(posedge clk_i) rx_watchdog_expired_o);
endmodule : mwj_regs

// [hw/mwj_cfg.svh]
// Offsets, field positions, write masks and timing counts for the watchdog/jabber register bank
`ifndef MWJ_CFG_SVH
`define MWJ_CFG_SVH
`define MWJ_OFF_CTRL 8'h78
`define MWJ_OFF_STAT 8'h80
`define MWJ_OFF_IEN 8'h84
`define MWJ_B_RXINV 28
`define MWJ_B_REL_SEL 5
`define MWJ_B_WD_DIS 4
`define MWJ_B_JAB_SEL 2
`define MWJ_B_JAB_IMM 1
`define MWJ_B_JAB_DIS 0
`define MWJ_B_ETX 31
`define MWJ_B_ERX 30
`define MWJ_B_LNK 29
`define MWJ_B_DEF 28
`define MWJ_B_PAU 26
`define MWJ_B_NSUM 16
`define MWJ_B_ASUM 15
`define MWJ_CTRL_WMASK 32'h00000037
`define MWJ_ADD_MASK 32'hf4018000
`define MWJ_CLK_NS 50
`define MWJ_NS_100 10
`define MWJ_NS_10 100
`define MWJ_JAB_FAST_US 2600
`define MWJ_JAB_SLOW_US 26000
`define MWJ_HOLD_FAST_US 42000
`define MWJ_HOLD_SLOW_US 420000
`define MWJ_JAB_BYTES 2560
`define MWJ_WD_BYTES 2560
`define MWJ_REL_SHORT_BT 24
`define MWJ_REL_LONG_BT 48
`define MWJ_US_CYC(us) ((us) * 1000 / `MWJ_CLK_NS)
`define MWJ_BT_CYC(bt, ns) ((((bt) * (ns)) + `MWJ_CLK_NS - 1) / `MWJ_CLK_NS)
`endif

// [hw/mwj_pkg.sv]
// Types shared by the watchdog/jabber register bank
package mwj_pkg;
  typedef struct packed {
    logic tx_in_fifo;
    logic rx_first_desc;
    logic link_change;
    logic tx_deferred;
    logic pause_rx;
  } mwj_events_s;
  typedef enum logic [1:0] {
    MWJ_J_IDLE = 2'b00,
    MWJ_J_RUN = 2'b01,
    MWJ_J_HOLD = 2'b10,
    MWJ_J_WAIT = 2'b11
  } mwj_jab_e;
endpackage : mwj_pkg

// [hw/mwj_cnt.sv]
// Saturating cycle counter with clear and terminal flag
`timescale 1ns/10ps
module mwj_cnt #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clr_i,
  input wire logic run_i,
  input wire logic [W-1:0] limit_i,
  // Result
  output logic done_o
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  // Next count, held at limit
  always_comb begin
    next_cnt = cnt;
    if (clr_i) begin
      next_cnt = '0;
    end else if (run_i && cnt < limit_i) begin
      next_cnt = cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // Count register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign done_o = (cnt >= limit_i) && !clr_i;
endmodule : mwj_cnt

// [verification/mwj_host.sv]
// Host model: AXI4-Lite master in place of driver software
`timescale 1ns/10ps
module mwj_host (
  // Clock
  input wire logic clk_i,
  // Write channels
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  // Read channels
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // Bus idle at time zero
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  // One write; a one written to a status bit clears it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= 4'hf;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready_i) awvalid_o <= 1'b0;
      if (wready_i) wvalid_o <= 1'b0;
    end while (!bvalid_i);
    bready_o <= 1'b0;
    r = bresp_i;
  endtask : wr
  // One read; waits however long the answer takes
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready_i) arvalid_o <= 1'b0;
    end while (!rvalid_i);
    rready_o <= 1'b0;
    d = rdata_i;
    r = rresp_i;
  endtask : rd
endmodule : mwj_host

// [verification/tb_top.sv]
// Self-checking bench for the watchdog/jabber register bank
`timescale 1ns/10ps
`include "mwj_cfg.svh"
module tb_top;
  localparam int JF = 40;
  localparam int JS = 60;
  localparam int HF = 30;
  localparam int HS = 50;
  localparam logic [7:0] CT = `MWJ_OFF_CTRL;
  localparam logic [7:0] ST = `MWJ_OFF_STAT;
  localparam logic [7:0] EN = `MWJ_OFF_IEN;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic rx_clock_invert_load_i = 1'b0;
  logic rx_clock_invert_val_i = 1'b0;
  mwj_pkg::mwj_events_s events_i = '0;
  logic pause_enabled_i = 1'b1;
  logic [14:0] main_status_set_i = '0;
  logic speed_100_i = 1'b1;
  logic tx_active_i = 1'b0;
  logic rx_active_i = 1'b0;
  logic rx_carrier_i = 1'b0;
  logic mii_rx_clk_i = 1'b1;
  logic mii_rx_clk_o, tx_blocked_o, rx_watchdog_expired_o, rx_watchdog_release_o;
  logic irq_o, main_normal_summary_o, main_abnormal_summary_o;
  int mismatches = 0;
  int num_checks = 0;
  // Design with short jabber and hold-off counts
  mwj_regs #(.JAB_FAST_CYC(JF), .JAB_SLOW_CYC(JS), .HOLD_FAST_CYC(HF),
    .HOLD_SLOW_CYC(HS)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i), .rx_clock_invert_load_i(rx_clock_invert_load_i),
    .rx_clock_invert_val_i(rx_clock_invert_val_i), .events_i(events_i),
    .pause_enabled_i(pause_enabled_i), .main_status_set_i(main_status_set_i),
    .speed_100_i(speed_100_i), .tx_active_i(tx_active_i), .rx_active_i(rx_active_i),
    .rx_carrier_i(rx_carrier_i), .mii_rx_clk_i(mii_rx_clk_i), .mii_rx_clk_o(mii_rx_clk_o),
    .tx_blocked_o(tx_blocked_o), .rx_watchdog_expired_o(rx_watchdog_expired_o),
    .rx_watchdog_release_o(rx_watchdog_release_o), .irq_o(irq_o),
    .main_normal_summary_o(main_normal_summary_o),
    .main_abnormal_summary_o(main_abnormal_summary_o));
  // Host on the register bus
  mwj_host host (.clk_i(clk_i), .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i),
    .awready_i(s_axi_awready_o), .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i),
    .wvalid_o(s_axi_wvalid_i), .wready_i(s_axi_wready_o), .bresp_i(s_axi_bresp_o),
    .bvalid_i(s_axi_bvalid_o), .bready_o(s_axi_bready_i), .araddr_o(s_axi_araddr_i),
    .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o), .rdata_i(s_axi_rdata_o),
    .rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i));
  // Clock
  always #25 clk_i = ~clk_i;
  // Compare and count
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Register read against expectation
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk(n, d, e);
    chk("rresp", r, 2'h0);
  endtask : rchk
  // Register write with OKAY answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.wr(a, d, r);
    chk("bresp", r, 2'h0);
  endtask : wr
  // Idle cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  // One-cycle event pulse
  task automatic pulse(input logic [4:0] e, input logic [14:0] m);
    @(posedge clk_i);
    events_i <= e;
    main_status_set_i <= m;
    @(posedge clk_i);
    events_i <= '0;
    main_status_set_i <= '0;
  endtask : pulse
  // Cycles until an output reaches a level, bounded
  task automatic meas(input int w, input logic lv, input int lim, output int n);
    logic s;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      s = w == 0 ? tx_blocked_o : w == 1 ? rx_watchdog_release_o : rx_watchdog_expired_o;
    end while (n < lim && s !== lv);
    @(posedge clk_i);
  endtask : meas
  // Count lies within register latency of its target
  function automatic logic inr(input int n, input int e);
    return n >= e - 1 && n <= e + 3;
  endfunction : inr
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // Reset values, unmapped place, control write mask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rchk("ctl rst", CT, 32'h0);
    rchk("sts rst", ST, 32'h0);
    rchk("ien rst", EN, 32'h0);
    host.rd(8'h7c, d, r);
    chk("bad rresp", r, 2'h2);
    chk("bad rdata", d, 32'h0);
    host.wr(8'h88, 32'hffffffff, r);
    chk("bad bresp", r, 2'h2);
    wr(CT, 32'hffffffff);
    rchk("ctl mask", CT, 32'h00000037);
    wr(CT, 32'h0);
  endtask : t_regs
  // Receive clock inversion loaded from memory
  task automatic t_inv();
    @(posedge clk_i);
    rx_clock_invert_load_i <= 1'b1;
    rx_clock_invert_val_i <= 1'b1;
    @(posedge clk_i);
    rx_clock_invert_load_i <= 1'b0;
    wr(CT, 32'h0);
    rchk("inv bit", CT, 32'h10000000);
    chk("clk inv", mii_rx_clk_o, 1'b0);
    @(posedge clk_i);
    rx_clock_invert_load_i <= 1'b1;
    rx_clock_invert_val_i <= 1'b0;
    @(posedge clk_i);
    rx_clock_invert_load_i <= 1'b0;
    cyc(3);
    chk("clk thru", mii_rx_clk_o, 1'b1);
  endtask : t_inv
  // Each added event latches, ignores zero, clears on one
  task automatic t_ev();
    logic [31:0] b [5] = '{32'h80000000, 32'h40000000, 32'h20000000, 32'h10000000,
      32'h04000000};
    logic [31:0] e;
    wr(EN, 32'hc0000000);
    for (int i = 0; i < 5; i++) begin
      e = b[i] | (i < 2 ? 32'h00010000 : 32'h00008000);
      pulse(5'h10 >> i, 15'h0);
      rchk("latch", ST, e);
      wr(ST, 32'h0);
      rchk("w0 kept", ST, e);
      wr(ST, e);
      rchk("w1 clr", ST, 32'h0);
    end
    wr(EN, 32'h0);
    pause_enabled_i <= 1'b0;
    pulse(5'h19, 15'h0);
    rchk("gated", ST, 32'h0);
    pause_enabled_i <= 1'b1;
  endtask : t_ev
  // Request line, summary folds and low aliases
  task automatic t_irq();
    wr(EN, 32'h20008000);
    pulse(5'h04, 15'h0);
    cyc(2);
    chk("irq lnk", irq_o, 1'b1);
    chk("abn fold", main_abnormal_summary_o, 1'b1);
    chk("nrm idle", main_normal_summary_o, 1'b0);
    wr(ST, 32'h20008000);
    cyc(2);
    chk("irq off", irq_o, 1'b0);
    chk("abn off", main_abnormal_summary_o, 1'b0);
    wr(EN, 32'h80010000);
    pulse(5'h10, 15'h0);
    cyc(2);
    chk("nrm fold", main_normal_summary_o, 1'b1);
    wr(ST, 32'h80010000);
    wr(EN, 32'h00007fff);
    rchk("ien alias", EN, 32'h00007fff);
    pulse(5'h0, 15'h0004);
    cyc(2);
    chk("irq alias", irq_o, 1'b1);
    rchk("sts alias", ST, 32'h00000004);
    wr(ST, 32'h00000004);
    rchk("alias clr", ST, 32'h0);
    wr(EN, 32'h0);
  endtask : t_irq
  // Reset in mid-run clears latched status, enables and request
  task automatic t_rst();
    wr(EN, 32'h20000000);
    pulse(5'h04, 15'h0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    cyc(16);
    rst_i <= 1'b0;
    rchk("sts clr", ST, 32'h0);
    rchk("ien clr", EN, 32'h0);
    chk("irq clr", irq_o, 1'b0);
  endtask : t_rst
  // One frame against the jabber timer; hold below zero means never cut
  task automatic jab(input logic [31:0] c, input logic sp, input int lim, input int hold);
    int n;
    wr(CT, c);
    speed_100_i <= sp;
    tx_active_i <= 1'b1;
    meas(0, 1'b1, lim + 10, n);
    if (hold < 0) begin
      chk("never cut", n, lim + 10);
    end else begin
      chk("cut time", inr(n, lim), 1'b1);
      meas(0, 1'b0, hold + 10, n);
      chk("hold time", inr(n, hold), 1'b1);
    end
    tx_active_i <= 1'b0;
    cyc(4);
  endtask : jab
  // Jabber cut-off, hold-off, immediate re-enable, disable, restart
  task automatic t_jab();
    jab(32'h0, 1'b1, JF, HF);
    jab(32'h0, 1'b0, JS, HS);
    jab(32'h4, 1'b1, 4096, HF);
    jab(32'h4, 1'b0, 40960, HS);
    jab(32'h2, 1'b1, JF, -1);
    jab(32'h1, 1'b1, JF, -1);
    wr(CT, 32'h0);
    tx_active_i <= 1'b1;
    cyc(JF - 5);
    chk("part uncut", tx_blocked_o, 1'b0);
    tx_active_i <= 1'b0;
    cyc(2);
    jab(32'h0, 1'b1, JF, HF);
  endtask : t_jab
  // Receive watchdog expiry, disable and release time
  task automatic t_wd();
    int n;
    speed_100_i <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wr(CT, k ? 32'h10 : 32'h0);
      rx_active_i <= 1'b1;
      meas(2, 1'b1, 4200, n);
      chk("wd expire", k ? n == 4200 : inr(n, 4096), 1'b1);
      rx_active_i <= 1'b0;
      wr(CT, k ? 32'h20 : 32'h0);
      rx_carrier_i <= 1'b1;
      cyc(6);
      chk("rel low", rx_watchdog_release_o, 1'b0);
      rx_carrier_i <= 1'b0;
      meas(1, 1'b1, 40, n);
      chk("rel time", inr(n, k ? 10 : 5), 1'b1);
    end
  endtask : t_wd
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_inv();
    t_ev();
    t_irq();
    t_rst();
    t_jab();
    t_wd();
    complete_run();
  end
  // Hang guard
  initial begin
    #5000000;
    mismatches++;
    complete_run();
  end
endmodule : tb_top
